/* File: design/spi_port_pkg.sv */
// Operation
// - Bytes move MSB first, full duplex
// - Master mode blocked at core divide 6, 7
// - Transmit hold feeds shifter onto MOSI/MISO
// - Status bit 0 shows transmit hold valid
// - Status bit 3 shows unread receive byte
// - Status bit 5 flags lost receive byte
// - MISO input as master, output as slave
// - MOSI output as master, input as slave
// - One byte takes eight serial clock periods
// - SCLK driven as master, sampled as slave
// - Master clock is core over 2*(div+1)
// - Launch on one edge, sample the other
// - Polarity and phase match on both ends
// - Slave select low frames byte exchanges as slave; master mode ignores it
package spi_port_pkg;

  // Register map, byte addresses
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] DIV_OFFSET    = 8'h04;
  localparam logic [7:0] CDSET_OFFSET  = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] TX_OFFSET     = 8'h10;
  localparam logic [7:0] RX_OFFSET     = 8'h14;

  // Status field positions
  localparam int STAT_TX_VALID = 0;
  localparam int STAT_BUSY     = 1;
  localparam int STAT_RX_VALID = 3;
  localparam int STAT_OVERFLOW = 5;

  // Control width, reset values and master core divide limit
  localparam int          CTRL_W       = 4;
  localparam logic [3:0]  CTRL_RESET   = 4'h0;
  localparam logic [7:0]  DIV_RESET    = 8'h05;
  localparam logic [2:0]  CDSET_RESET  = 3'h0;
  localparam logic [2:0]  CD_MASTER_LIMIT = 3'h6;

  // Byte framing: sixteen serial clock edges per byte
  localparam int         BYTE_W    = 8;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam int         BUF_DEPTH = 2;

  typedef struct packed {
    logic cpha;
    logic cpol;
    logic master;
    logic enable;
  } ctrl_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_MASTER = 2'b01,
    ST_SLAVE  = 2'b10
  } xfer_state_type;

endpackage : spi_port_pkg

/* File: design/spi_master_slave_port.sv */
module spi_master_slave_port
  import spi_port_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe_out,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_out,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_out,
  input  wire logic        cs_n_in
);

  // Register state
  ctrl_type             ctrl;
  ctrl_type             next_ctrl;
  logic [DIV_W-1:0]     divider;
  logic [DIV_W-1:0]     next_divider;
  logic [2:0]           cd_set;
  logic [2:0]           next_cd_set;
  logic [BYTE_W-1:0]    tx_hold_reg;
  logic [BYTE_W-1:0]    next_tx_hold_reg;
  logic                 tx_valid;
  logic                 next_tx_valid;
  logic                 overflow;
  logic                 next_overflow;
  logic [31:0]          next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;

  // Transfer state
  xfer_state_type       state;
  xfer_state_type       next_state;
  logic [DIV_W-1:0]     div_cnt;
  logic [DIV_W-1:0]     next_div_cnt;
  logic [3:0]           edge_cnt;
  logic [3:0]           next_edge_cnt;
  logic                 sclk_q;
  logic                 next_sclk;
  logic [BYTE_W-1:0]    tx_shift;
  logic [BYTE_W-1:0]    next_tx_shift;
  logic [BYTE_W-1:0]    rx_shift;
  logic [BYTE_W-1:0]    next_rx_shift;
  logic                 load_tx;
  logic                 push;
  logic                 sclk_edge;
  logic                 sample;
  logic                 din;
  logic                 cd_ok;

  // Receive buffer
  logic [BYTE_W-1:0]    rx_buf [BUF_DEPTH];
  logic                 wr_ptr;
  logic                 next_wr_ptr;
  logic                 rd_ptr;
  logic                 next_rd_ptr;
  logic [1:0]           buf_cnt;
  logic [1:0]           next_buf_cnt;
  logic                 buf_ready;
  logic                 buf_valid;
  logic                 pop;
  logic [BYTE_W-1:0]    rx_hold_reg;

  // Pin synchronisers
  logic [3:0]           sync1;
  logic [3:0]           sync2;
  logic                 sclk_s3;
  logic                 cs_s3;
  logic                 next_sclk_oe;
  logic                 next_mosi_oe;
  logic                 next_miso_oe;

  // APB decode
  logic                 access;
  logic                 wr_en;
  logic                 rd_en;
  logic                 mapped;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  // Slave pins settle through two flops before use
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sync1   <= 4'hF;
      sync2   <= 4'hF;
      sclk_s3 <= 1'b1; // Matches the first flop's reset level
      cs_s3   <= 1'b1;
    end else begin
      sync1   <= {cs_n_in, sclk_in, mosi_in, miso_in};
      sync2   <= sync1;
      sclk_s3 <= sync2[2];
      cs_s3   <= sync2[3];
    end
  end

  // One wait state on every access keeps reads registered
  assign access    = psel_in & penable_in & ~pready_out;
  // Writes land at the completing edge, while the request still stands
  assign wr_en     = psel_in & penable_in & pready_out & pwrite_in;
  assign rd_en     = access & ~pwrite_in;
  assign buf_ready = (buf_cnt != 2'h2);
  assign buf_valid = (buf_cnt != 2'h0);
  assign rx_hold_reg = rx_buf[rd_ptr];
  assign pop       = rd_en && paddr_in == RX_OFFSET && buf_valid;
  assign cd_ok     = cd_set < CD_MASTER_LIMIT;
  assign din       = ctrl.master ? sync2[0] : sync2[1];

  // Serial engine, shared by master and slave
  always_comb begin
    next_state    = state;
    next_div_cnt  = div_cnt;
    next_edge_cnt = edge_cnt;
    next_sclk     = sclk_q;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    load_tx       = 1'b0;
    push          = 1'b0;
    sclk_edge     = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_sclk     = ctrl.cpol;
        next_div_cnt  = '0;
        next_edge_cnt = 4'h0;
        // Master waits for buffer room rather than lose a byte
        if (ctrl.enable && ctrl.master && cd_ok && tx_valid &&
            buf_ready) begin
          load_tx       = 1'b1;
          next_tx_shift = tx_hold_reg;
          next_state    = ST_MASTER;
        end else if (ctrl.enable && !ctrl.master && !sync2[3] &&
                     cs_s3) begin
          load_tx       = tx_valid;
          next_tx_shift = tx_valid ? tx_hold_reg : 8'h00;
          next_state    = ST_SLAVE;
        end
      end
      ST_MASTER: begin
        // Half period of divider+1 core cycles
        if (div_cnt == divider) begin
          next_div_cnt = '0;
          sclk_edge    = 1'b1;
          next_sclk    = ~sclk_q;
        end else begin
          next_div_cnt = div_cnt + 1'b1;
        end
        if (!ctrl.enable || !ctrl.master) begin
          next_state = ST_IDLE;
        end
      end
      ST_SLAVE: begin
        sclk_edge = sync2[2] ^ sclk_s3;
        // Select high ends the frame, a partial byte is dropped
        if (sync2[3] || !ctrl.enable || ctrl.master) begin
          next_state = ST_IDLE;
          sclk_edge  = 1'b0;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Even edges lead; phase picks which edge samples
    sample = ~edge_cnt[0] ^ ctrl.cpha;
    if (sclk_edge) begin
      next_edge_cnt = edge_cnt + 1'b1;
      if (sample) begin
        next_rx_shift = {rx_shift[BYTE_W-2:0], din};
      end else if (!(ctrl.cpha && edge_cnt == 4'h0)) begin
        next_tx_shift = {tx_shift[BYTE_W-2:0], 1'b0};
      end
      if (edge_cnt == LAST_EDGE) begin
        push = 1'b1;
        if (state == ST_MASTER) begin
          next_state = ST_IDLE;
        end else begin
          // Next byte of the frame comes from the hold register
          load_tx       = tx_valid;
          next_tx_shift = tx_valid ? tx_hold_reg : 8'h00;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state    <= ST_IDLE;
      div_cnt  <= '0;
      edge_cnt <= 4'h0;
      sclk_q   <= 1'b0;
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
    end else begin
      state    <= next_state;
      div_cnt  <= next_div_cnt;
      edge_cnt <= next_edge_cnt;
      sclk_q   <= next_sclk;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
    end
  end

  // Two-entry receive buffer, head is the receive hold register
  always_comb begin
    next_wr_ptr  = wr_ptr;
    next_rd_ptr  = rd_ptr;
    next_buf_cnt = buf_cnt;
    if (push && buf_ready) begin
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    next_buf_cnt = buf_cnt + {1'b0, push & buf_ready} - {1'b0, pop};
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      wr_ptr  <= next_wr_ptr;
      rd_ptr  <= next_rd_ptr;
      buf_cnt <= next_buf_cnt;
    end
  end

  // Data array needs no reset
  always_ff @(posedge mclk_in) begin
    if (push && buf_ready) begin
      rx_buf[wr_ptr] <= next_rx_shift;
    end
  end

  // Register file and APB answer
  always_comb begin
    next_ctrl        = ctrl;
    next_divider     = divider;
    next_cd_set      = cd_set;
    next_tx_hold_reg = tx_hold_reg;
    next_tx_valid    = tx_valid;
    next_overflow    = overflow;
    next_prdata      = 32'h0000_0000;
    next_pready      = access;
    next_pslverr     = 1'b0;
    mapped = paddr_in == CTRL_OFFSET || paddr_in == DIV_OFFSET ||
             paddr_in == CDSET_OFFSET || paddr_in == STATUS_OFFSET ||
             paddr_in == TX_OFFSET || paddr_in == RX_OFFSET;
    if (access && !mapped) begin
      next_pslverr = 1'b1;
    end
    if (load_tx) begin
      next_tx_valid = 1'b0;
    end
    // Clear by writing one; a new loss in the same cycle wins
    if (wr_en && paddr_in == STATUS_OFFSET &&
        pwdata_in[STAT_OVERFLOW]) begin
      next_overflow = 1'b0;
    end
    if (push && !buf_ready) begin
      next_overflow = 1'b1;
    end
    if (wr_en) begin
      unique case (paddr_in)
        CTRL_OFFSET:  next_ctrl    = pwdata_in[CTRL_W-1:0];
        DIV_OFFSET:   next_divider = pwdata_in[DIV_W-1:0];
        CDSET_OFFSET: next_cd_set  = pwdata_in[2:0];
        TX_OFFSET: begin
          next_tx_hold_reg = pwdata_in[BYTE_W-1:0];
          next_tx_valid    = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (rd_en) begin
      unique case (paddr_in)
        CTRL_OFFSET:  next_prdata[CTRL_W-1:0] = ctrl;
        DIV_OFFSET:   next_prdata[DIV_W-1:0]  = divider;
        CDSET_OFFSET: next_prdata[2:0]        = cd_set;
        STATUS_OFFSET: begin
          next_prdata[STAT_TX_VALID] = tx_valid;
          next_prdata[STAT_BUSY]     = state != ST_IDLE;
          next_prdata[STAT_RX_VALID] = buf_valid;
          next_prdata[STAT_OVERFLOW] = overflow;
        end
        TX_OFFSET:    next_prdata[BYTE_W-1:0] = tx_hold_reg;
        RX_OFFSET:    next_prdata[BYTE_W-1:0] = rx_hold_reg;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ctrl        <= CTRL_RESET;
      divider     <= DIV_RESET;
      cd_set      <= CDSET_RESET;
      tx_hold_reg <= 8'h00;
      tx_valid    <= 1'b0;
      overflow    <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      ctrl        <= next_ctrl;
      divider     <= next_divider;
      cd_set      <= next_cd_set;
      tx_hold_reg <= next_tx_hold_reg;
      tx_valid    <= next_tx_valid;
      overflow    <= next_overflow;
      prdata_out  <= next_prdata;
      pready_out  <= next_pready;
      pslverr_out <= next_pslverr;
    end
  end

  // Pin directions follow the mode
  always_comb begin
    next_sclk_oe = ctrl.enable & ctrl.master;
    next_mosi_oe = ctrl.enable & ctrl.master;
    next_miso_oe = ctrl.enable & ~ctrl.master & ~sync2[3];
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sclk_oe_out <= 1'b0;
      mosi_oe_out <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      sclk_oe_out <= next_sclk_oe;
      mosi_oe_out <= next_mosi_oe;
      miso_oe_out <= next_miso_oe;
    end
  end

  // Shifter MSB drives whichever data pin is enabled
  assign sclk_out = sclk_q;
  assign mosi_out = tx_shift[BYTE_W-1];
  assign miso_out = tx_shift[BYTE_W-1];

  chk_master_cd_block: assert property (
    state == ST_IDLE && !cd_ok |=> state != ST_MASTER)
    else $error("master started at blocked core divide");

  chk_shift_load: assert property (
    load_tx |=> tx_shift == $past(tx_hold_reg))
    else $error("shifter not loaded from hold register");

  chk_tx_valid_set: assert property (
    wr_en && paddr_in == TX_OFFSET |=> tx_valid ##1 tx_valid || $past(load_tx))
    else $error("transmit valid not set by write");

  chk_rx_status: assert property (
    rd_en && paddr_in == STATUS_OFFSET |=>
      prdata_out[STAT_RX_VALID] == ($past(buf_cnt) != 2'h0))
    else $error("receive valid status wrong");

  chk_overflow_set: assert property (
    push && buf_cnt == 2'h2 |=> overflow ##1 overflow || $past(wr_en))
    else $error("lost byte not flagged");

  chk_miso_dir: assert property (
    ctrl.enable && ctrl.master |=> !miso_oe_out)
    else $error("miso driven in master mode");

  chk_mosi_dir: assert property (
    ctrl.enable && !ctrl.master |=> !mosi_oe_out && !sclk_oe_out)
    else $error("mosi or sclk driven in slave mode");

  // Core cycles spent in the current master byte, for the length check
  logic [DIV_W+3:0]     mst_cycles;
  always_ff @(posedge mclk_in) begin
    if (srst_in || state != ST_MASTER) begin
      mst_cycles <= '0;
    end else begin
      mst_cycles <= mst_cycles + 1'b1;
    end
  end

  chk_byte_edges: assert property (
    push && state == ST_MASTER |-> mst_cycles == {divider, 4'hF})
    else $error("byte ended off sixteenth edge");

  chk_sclk_rate: assert property (
    state == ST_MASTER && div_cnt != divider |=> $stable(sclk_q))
    else $error("serial clock toggled early");

  chk_tx_clear: assert property (
    load_tx && !(wr_en && paddr_in == TX_OFFSET) |=> !tx_valid)
    else $error("transmit valid not cleared on load");

  cov_master_byte: cover property (state == ST_MASTER && push);
  cov_slave_byte:  cover property (state == ST_SLAVE && push);
  cov_overflow:    cover property (push && !buf_ready);
  cov_cpha_one:    cover property (push && ctrl.cpha);

endmodule : spi_master_slave_port

/* File: sim/spi_far_slave.sv */
module spi_far_slave
  import spi_port_pkg::*;
(
  input  wire logic       sclk_in,
  input  wire logic       mosi_in,
  input  wire ctrl_type   ctrl_in,
  input  wire logic       load_in,
  input  wire logic [7:0] reply_in,
  output logic            miso_out,
  output logic      [7:0] got_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx;

  // With phase one a reload shows the inverse until first launch; always selected,
  // so config changes must precede a reload
  always @(sclk_in or posedge load_in) begin
    if (load_in) begin
      tx = reply_in;
      miso_out = ctrl_in.cpha ? ~reply_in[7] : reply_in[7];
    end else if ((sclk_in !== ctrl_in.cpol) ^ ctrl_in.cpha) begin
      got_out = {got_out[6:0], mosi_in};
    end else if (ctrl_in.cpha) begin
      miso_out = tx[7];
      tx = {tx[6:0], ~tx[0]};
    end else begin
      tx = {tx[6:0], ~tx[0]};
      miso_out = tx[7];
    end
  end
endmodule : spi_far_slave

/* File: sim/tb_top.sv */
module tb_top
  import spi_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'h0;
  logic        srst = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  logic        sclk_w, sclk_out, sclk_oe, bs = 1'h0;
  logic        mosi_w, mosi_out, mosi_oe, bm = 1'h0;
  logic        miso_w, miso_out, miso_oe, cs_n = 1'h1;
  logic        far_load = 1'h0, sclk_last = 1'h0;
  logic [2:0]  pins_oe;
  logic [7:0]  far_reply = 8'h00, far_got;
  ctrl_type    cfg = ctrl_type'(4'h0);
  int          err_total = 0, checks = 0, cyc = 0, tog = 0;
  int          tog_cyc = 0, gap_bad = 0, exp_gap = 0;

  // Pin levels from whoever holds the enable
  assign sclk_w = sclk_oe ? sclk_out : bs;
  assign mosi_w = mosi_oe ? mosi_out : bm;
  assign pins_oe = {sclk_oe, mosi_oe, miso_oe};

  spi_master_slave_port u_spi_master_slave_port (
    .mclk_in(mclk), .srst_in(srst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .sclk_in(sclk_w), .sclk_out(sclk_out),
    .sclk_oe_out(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe_out(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe_out(miso_oe), .cs_n_in(cs_n));

  spi_far_slave u_spi_far_slave (
    .sclk_in(sclk_w), .mosi_in(mosi_w), .ctrl_in(cfg),
    .load_in(far_load), .reply_in(far_reply), .miso_out(miso_w),
    .got_out(far_got));

  initial begin
    forever #10 mclk = ~mclk;
  end

  // Serial clock toggle count, spacing, and run ceiling
  always @(posedge mclk) begin
    cyc++;
    if (sclk_out !== sclk_last) begin
      if (tog != 0 && cyc - tog_cyc != exp_gap) gap_bad++;
      tog++;
      tog_cyc = cyc;
    end
    sclk_last = sclk_out;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  function automatic logic [31:0] exp_stat(input logic t, r, o);
    return {26'h0, o, 1'h0, r, 2'h0, t};
  endfunction : exp_stat

  // Divider that software uses at each core divide setting
  function automatic logic [7:0] div_for(input logic [2:0] cd);
    return 8'((32'd6 << cd) - 32'd1);
  endfunction : div_for

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'h1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q,
                    output logic e);
    apb(1'h0, a, 32'h0, q, e);
  endtask : rd

  task automatic mxfer(input logic [1:0] mode, input logic [7:0] div,
                       input logic [2:0] core_div);
    logic [31:0] q;
    logic        e;
    logic [7:0]  t, r;
    t = 8'($urandom);
    r = 8'($urandom);
    wr(CTRL_OFFSET, {28'h0, mode, 2'h3});
    wr(DIV_OFFSET, {24'h0, div});
    rd(DIV_OFFSET, q, e);
    chk("divider", q, {24'h0, div});
    wr(CDSET_OFFSET, {29'h0, core_div});
    @(posedge mclk);
    cfg <= ctrl_type'({mode, 2'h3});
    far_reply <= r;
    far_load <= 1'h1;
    @(posedge mclk);
    far_load <= 1'h0;
    tog = 0;
    gap_bad = 0;
    exp_gap = int'(div) + 1;
    wr(TX_OFFSET, {24'h0, t});
    if (core_div >= CD_MASTER_LIMIT) begin
      // Nothing may start, so a fixed wait is the only way
      repeat (80) @(posedge mclk);
      chk("held clock", tog, 0);
      rd(STATUS_OFFSET, q, e);
      chk("held status", q, exp_stat(1'h1, 1'h0, 1'h0));
      wr(CDSET_OFFSET, 32'h0);
    end
    do rd(STATUS_OFFSET, q, e); while (q[1] !== 1'h0 || q[0] !== 1'h0);
    chk("status", q, exp_stat(1'h0, 1'h1, 1'h0));
    chk("pin enables", pins_oe, 3'h6);
    chk("toggles", tog, 16);
    chk("spacing", gap_bad, 0);
    chk("far byte", far_got, t);
    rd(RX_OFFSET, q, e);
    chk("rx byte", q, {24'h0, r});
    rd(STATUS_OFFSET, q, e);
    chk("drained", q, 32'h0);
    $display("master mode %0d done", mode);
  endtask : mxfer

  task automatic sbyte(input logic [1:0] mode, input logic [7:0] mo,
                       output logic [7:0] mi);
    for (int i = 7; i >= 0; i--) begin
      if (!mode[1]) bm <= mo[i];
      repeat (6) @(posedge mclk);
      bs <= ~mode[0]; // Twelve cycles a bit
      if (mode[1]) bm <= mo[i];
      else mi[i] = miso_out;
      repeat (6) @(posedge mclk);
      bs <= mode[0];
      if (mode[1]) mi[i] = miso_out;
    end
  endtask : sbyte

  // Slave session of n bytes; a third byte finds the buffer full
  task automatic sess(input logic [1:0] mode, input int n);
    logic [31:0] q;
    logic        e;
    logic [7:0]  t, g;
    logic [7:0]  m [3];
    t = 8'($urandom);
    wr(CTRL_OFFSET, {28'h0, mode, 2'h1});
    bs <= mode[0];
    wr(TX_OFFSET, {24'h0, t});
    @(posedge mclk);
    cs_n <= 1'h0;
    repeat (6) @(posedge mclk);
    chk("pin enables", pins_oe, 3'h1);
    for (int k = 0; k < n; k++) begin
      m[k] = 8'($urandom);
      sbyte(mode, m[k], g);
      chk("miso byte", g, k == 0 ? t : 8'h00);
    end
    @(posedge mclk);
    cs_n <= 1'h1;
    bm <= ~bm;
    repeat (6) @(posedge mclk);
    rd(STATUS_OFFSET, q, e);
    chk("status", q, exp_stat(1'h0, 1'h1, n > 2));
    for (int k = 0; k < n && k < 2; k++) begin
      rd(RX_OFFSET, q, e);
      chk("rx byte", q, {24'h0, m[k]});
    end
    if (n > 2) wr(STATUS_OFFSET, 32'h20);
    rd(STATUS_OFFSET, q, e);
    chk("cleared", q, 32'h0);
    $display("slave mode %0d bytes %0d done", mode, n);
  endtask : sess

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Reset values, one unmapped place, then both modes
  initial begin
    logic [7:0]  ra [5];
    logic [31:0] q;
    logic        e;
    ra = '{CTRL_OFFSET, DIV_OFFSET, CDSET_OFFSET, STATUS_OFFSET, 8'h18};
    void'($urandom(55));
    repeat (4) @(posedge mclk);
    srst <= 1'h0;
    for (int k = 0; k < 5; k++) begin
      rd(ra[k], q, e);
      chk("reset value", q, k == 1 ? 32'(DIV_RESET) : 32'h0);
      chk("error flag", e, k == 4);
    end
    $display("reset values done");
    for (int k = 0; k < 6; k++) mxfer(2'(k), div_for(3'(k)), 3'(k));
    mxfer(2'h0, div_for(3'h0), 3'h6);
    mxfer(2'h3, div_for(3'h0), 3'h7);
    for (int k = 0; k < 4; k++) sess(2'(k), 1);
    sess(2'h2, 3);
    wrap_up();
  end
endmodule : tb_top
